// ==== hw/cfg_two_map.svh ====
// register offsets, field positions and timing counts for config word two
// assumes a 250 MHz system clock and byte addressing on the register bus
`ifndef CFG_TWO_MAP_SVH
`define CFG_TWO_MAP_SVH
`define CFG2_OFFSET 8'ha8
`define CFG2_RESET 32'h0000_0000
`define CTRL_OFFSET 8'hac
`define STAT_OFFSET 8'hb0
`define F_FREQ_HI 30
`define F_FREQ_LO 16
`define F_SLEEP_HI 15
`define F_SLEEP_LO 14
`define F_CUR_GAIN 13
`define F_VOLT_GAIN 12
`define F_LP_MODE 11
`define F_DITH_HI 10
`define F_DITH_LO 9
`define F_XCLK_EN 8
`define F_XCLK_HI 7
`define F_XCLK_LO 5
`define F_WDT_EN 4
`define F_WDT_HI 3
`define F_WDT_LO 2
`define F_TICK_SRC 1
`define F_FAULT_ACT 0
`define CLK_MHZ 250
// sleep delays in microseconds
`define SLEEP_US_0 50
`define SLEEP_US_1 200
`define SLEEP_US_2 20000
`define SLEEP_US_3 200000
// tickle intervals in milliseconds for pin tickles; serial is ten times
`define WDT_MS_0 100
`define WDT_MS_1 200
`define WDT_MS_2 500
`define WDT_MS_3 1000
`define WDT_SERIAL_MULT 10
`define XCLK_BASE_KHZ 8
`endif

// ==== hw/cfg_two_pkg.sv ====
// types for the configuration word two block
// assumes the map header supplies all numbers
package cfg_two_pkg;
  typedef struct packed {
    logic [14:0] full_scale_freq;
    logic [1:0] sleep_delay_sel;
    logic auto_current_gain_enable;
    logic auto_voltage_gain_enable;
    logic low_power_mode_select;
    logic [1:0] dither_depth_sel;
    logic external_clock_enable;
    logic [2:0] external_clock_rate_select;
    logic outside_watchdog_enable;
    logic [1:0] tickle_interval_select;
    logic tickle_source_select;
    logic watchdog_fault_action;
  } cfg_fields_s;
  typedef enum logic [1:0] {
    REF_ANALOG, REF_DUTY, REF_SERIAL, REF_FREQ
  } ref_source_e;
  typedef enum logic [1:0] {
    DITHER_OFF, DITHER_5, DITHER_7P5, DITHER_10
  } dither_e;
  typedef enum {
    ST_RUN, ST_IDLE
  } power_state_e;
endpackage : cfg_two_pkg

// ==== hw/cfg_two_regs.sv ====
// config word two register bank with sleep timer and outside watchdog
// assumes an axi4-lite master on the same clock and async pin inputs
`include "cfg_two_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cfg_two_regs
  import cfg_two_pkg::*;
#(
  parameter int unsigned CLK_MHZ = `CLK_MHZ,
  parameter int unsigned SLEEP_SCALE = 1,
  parameter int unsigned WDT_SCALE = 1
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // axi4-lite write channels
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read channels
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // speed reference from the control core
  input wire logic [1:0] i_ref_source,
  input wire logic i_ref_low,
  input wire logic [15:0] i_measured_freq,
  // watchdog tickles
  input wire logic i_serial_tickle,
  input wire logic i_pin_tickle,
  // settings toward the control core
  output cfg_two_pkg::cfg_fields_s o_cfg,
  output logic [15:0] o_freq_duty,
  output logic [19:0] o_xclk_khz,
  output logic o_use_ext_clk,
  output logic o_cur_gain_auto,
  output logic o_volt_gain_auto,
  output logic [6:0] o_dither_tenths_pct,
  output logic o_sleep,
  output logic o_standby,
  output logic o_wdt_fault,
  output logic o_stage_hiz
);
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int unsigned SLP0 = `SLEEP_US_0 * CLK_MHZ / SLEEP_SCALE;
  localparam int unsigned SLP1 = `SLEEP_US_1 * CLK_MHZ / SLEEP_SCALE;
  localparam int unsigned SLP2 = `SLEEP_US_2 * CLK_MHZ / SLEEP_SCALE;
  localparam int unsigned SLP3 = `SLEEP_US_3 * CLK_MHZ / SLEEP_SCALE;
  localparam int unsigned WD0 = `WDT_MS_0 * 1000 * CLK_MHZ / WDT_SCALE;
  localparam int unsigned WD1 = `WDT_MS_1 * 1000 * CLK_MHZ / WDT_SCALE;
  localparam int unsigned WD2 = `WDT_MS_2 * 1000 * CLK_MHZ / WDT_SCALE;
  localparam int unsigned WD3 = `WDT_MS_3 * 1000 * CLK_MHZ / WDT_SCALE;
  logic [31:0] cfg_q, cfg_d;
  logic fault_q, fault_d, latched_q, latched_d, clr_fault;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic aw_ok, ar_ok;
  cfg_fields_s f;

  assign f = cfg_fields_s'(cfg_q[30:0]);
  assign o_cfg = f;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  // two flops before use; third flop only for edge detection
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= {i_pin_tickle, i_ref_low};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  logic ref_low, pin_tick_rise;
  assign ref_low = pin_s2_q[0];
  assign pin_tick_rise = pin_s2_q[1] & ~pin_s3_q[1];
  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // both address and data must be present; this avoids buffering either
  assign aw_ok = i_awvalid & i_wvalid & ~bvalid_q;
  assign o_awready = aw_ok;
  assign o_wready = aw_ok;
  assign ar_ok = i_arvalid & ~rvalid_q;
  assign o_arready = ar_ok;
  // write path and config register next value
  always_comb
  begin
    cfg_d = cfg_q;
    bvalid_d = bvalid_q & ~i_bready;
    bresp_d = bresp_q;
    clr_fault = 1'b0;
    if (aw_ok)
    begin
      bvalid_d = 1'b1;
      bresp_d = 2'h0;
      if (i_awaddr[7:2] == `CFG2_OFFSET >> 2)
      begin
        for (int b = 0; b < 4; b++)
          if (i_wstrb[b])
            cfg_d[8*b +: 8] = i_wdata[8*b +: 8];
      end
      else if (i_awaddr[7:2] == `CTRL_OFFSET >> 2)
        clr_fault = i_wstrb[0] & i_wdata[0];
      else
        bresp_d = 2'h2; // slverr on unmapped address
    end
  end
  // read path
  always_comb
  begin
    rvalid_d = rvalid_q & ~i_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_ok)
    begin
      rvalid_d = 1'b1;
      rresp_d = 2'h0;
      rdata_d = 32'h0; // the control word is write-only and reads as zero
      if (i_araddr[7:2] == `CFG2_OFFSET >> 2)
        rdata_d = cfg_q;
      else if (i_araddr[7:2] == `STAT_OFFSET >> 2)
        rdata_d = {28'h0, o_stage_hiz, o_standby, o_sleep, fault_q};
      else if (i_araddr[7:2] != `CTRL_OFFSET >> 2)
        rresp_d = 2'h2; // slverr on unmapped address
    end
  end
  // bus state registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cfg_q <= `CFG2_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      cfg_q <= cfg_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;
  // ----------------------------------------------------------------
  // sleep entry timer
  // ----------------------------------------------------------------
  logic [31:0] slp_cnt_q, slp_cnt_d, slp_limit;
  power_state_e pwr_q, pwr_d;
  // delay per code from the field
  always_comb
  begin
    unique case (f.sleep_delay_sel)
      2'h0: slp_limit = SLP0;
      2'h1: slp_limit = SLP1;
      2'h2: slp_limit = SLP2;
      2'h3: slp_limit = SLP3;
    endcase
  end
  // the low level is judged for whichever source the core selected
  always_comb
  begin
    slp_cnt_d = slp_cnt_q;
    pwr_d = pwr_q;
    if (!ref_low)
    begin
      slp_cnt_d = 32'h0;
      pwr_d = ST_RUN;
    end
    else if (pwr_q == ST_RUN)
    begin
      if (slp_cnt_q + 32'h1 >= slp_limit)
        pwr_d = ST_IDLE;
      else
        slp_cnt_d = slp_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      slp_cnt_q <= 32'h0;
      pwr_q <= ST_RUN;
    end
    else
    begin
      slp_cnt_q <= slp_cnt_d;
      pwr_q <= pwr_d;
    end
  end
  // idle flavour picked by the mode bit
  assign o_sleep = (pwr_q == ST_IDLE) & f.low_power_mode_select;
  assign o_standby = (pwr_q == ST_IDLE) & ~f.low_power_mode_select;
  // ----------------------------------------------------------------
  // outside watchdog
  // ----------------------------------------------------------------
  logic [31:0] wd_cnt_q, wd_cnt_d, wd_limit;
  logic tick;
  // only the selected source counts as a tickle
  assign tick = f.tickle_source_select ? pin_tick_rise
                                       : i_serial_tickle;
  always_comb
  begin
    unique case (f.tickle_interval_select)
      2'h0: wd_limit = WD0;
      2'h1: wd_limit = WD1;
      2'h2: wd_limit = WD2;
      2'h3: wd_limit = WD3;
    endcase
    if (!f.tickle_source_select)
      wd_limit = wd_limit * `WDT_SERIAL_MULT;
  end
  // the fault set wins over a clear in the same cycle
  always_comb
  begin
    wd_cnt_d = wd_cnt_q;
    fault_d = fault_q & ~clr_fault;
    latched_d = latched_q;
    if (!f.outside_watchdog_enable || tick)
      wd_cnt_d = 32'h0;
    else if (wd_cnt_q + 32'h1 >= wd_limit)
    begin
      wd_cnt_d = 32'h0;
      fault_d = 1'b1;
      if (f.watchdog_fault_action)
        latched_d = 1'b1;
    end
    else
      wd_cnt_d = wd_cnt_q + 32'h1;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wd_cnt_q <= 32'h0;
      fault_q <= 1'b0;
      latched_q <= 1'b0;
    end
    else
    begin
      wd_cnt_q <= wd_cnt_d;
      fault_q <= fault_d;
      latched_q <= latched_d;
    end
  end
  assign o_wdt_fault = fault_q;
  assign o_stage_hiz = latched_q; // cleared only by reset
  // ----------------------------------------------------------------
  // derived settings
  // ----------------------------------------------------------------
  logic [15:0] duty_q, duty_d;
  // division is heavy; registered once per cycle, zero scale gives full
  always_comb
  begin
    duty_d = 16'h0;
    if (i_ref_source == REF_FREQ)
    begin
      if (i_measured_freq >= {1'b0, f.full_scale_freq})
        duty_d = 16'hffff; // at or past full scale, or zero scale
      else
        duty_d = 16'((32'(i_measured_freq) << 16)
                 / 32'(f.full_scale_freq));
    end
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      duty_q <= 16'h0;
    else
      duty_q <= duty_d;
  end
  assign o_freq_duty = duty_q;
  assign o_xclk_khz = 20'(`XCLK_BASE_KHZ) << f.external_clock_rate_select;
  assign o_use_ext_clk = f.external_clock_enable;
  assign o_cur_gain_auto = f.auto_current_gain_enable;
  assign o_volt_gain_auto = f.auto_voltage_gain_enable;
  // depth in tenths of a percent
  always_comb
  begin
    unique case (dither_e'(f.dither_depth_sel))
      DITHER_OFF: o_dither_tenths_pct = 7'h00;
      DITHER_5: o_dither_tenths_pct = 7'h32;
      DITHER_7P5: o_dither_tenths_pct = 7'h4b;
      DITHER_10: o_dither_tenths_pct = 7'h64;
    endcase
  end
endmodule : cfg_two_regs
`default_nettype wire

// ==== dv/cfg_two_props.sv ====
// checker for config word two: bus answers and field decoding
// assumes it is bound to cfg_two_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module cfg_two_props
  import cfg_two_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // bus handshakes
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  // core side
  input wire logic [1:0] i_ref_source,
  input wire logic i_ref_low,
  input wire cfg_two_pkg::cfg_fields_s o_cfg,
  input wire logic [15:0] o_freq_duty,
  input wire logic [19:0] o_xclk_khz,
  input wire logic o_use_ext_clk,
  input wire logic o_cur_gain_auto,
  input wire logic o_volt_gain_auto,
  input wire logic [6:0] o_dither_tenths_pct,
  input wire logic o_sleep,
  input wire logic o_standby,
  input wire logic o_stage_hiz
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  logic [6:0] dith_exp;
  // expected depth in tenths of a percent
  assign dith_exp = o_cfg.dither_depth_sel == 2'h0 ? 7'h0 :
    o_cfg.dither_depth_sel == 2'h1 ? 7'h32 :
    o_cfg.dither_depth_sel == 2'h2 ? 7'h4b : 7'h64;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // decoded outputs follow the register in the same cycle; checks still skip cycles where it changes
  write_answer_a: assert property (i_awvalid && i_wvalid && o_awready &&
    o_wready |=> o_bvalid) else $error("write not answered");
  resp_hold_a: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  rate_decode_a: assert property ($stable(o_cfg) |->
    o_xclk_khz == (20'h8 << o_cfg.external_clock_rate_select))
    else $error("clock rate decode wrong");
  dither_decode_a: assert property ($stable(o_cfg) |->
    o_dither_tenths_pct == dith_exp) else $error("dither depth wrong");
  gain_clock_a: assert property ($stable(o_cfg) |->
    {o_use_ext_clk, o_cur_gain_auto, o_volt_gain_auto} ==
    {o_cfg.external_clock_enable, o_cfg.auto_current_gain_enable,
    o_cfg.auto_voltage_gain_enable}) else $error("enable bits wrong");
  idle_mode_a: assert property ($stable(o_cfg) |->
    !(o_sleep && !o_cfg.low_power_mode_select) &&
    !(o_standby && o_cfg.low_power_mode_select)) else $error("idle kind");
  idle_entry_a: assert property ($rose(o_sleep || o_standby) |->
    $past(i_ref_low, 3)) else $error("idle without low reference");
  wake_up_a: assert property (!i_ref_low [*4] |->
    !o_sleep && !o_standby) else $error("idle kept after wake");
  duty_zero_a: assert property ((i_ref_source != 2'h3) [*2] |->
    o_freq_duty == 16'h0) else $error("duty outside frequency mode");
  hiz_hold_a: assert property (o_stage_hiz |=> o_stage_hiz)
    else $error("high impedance released");
  cover property (o_bvalid && i_bready);
  cover property ($rose(o_sleep));
  cover property ($rose(o_stage_hiz));
endmodule : cfg_two_props
bind cfg_two_regs cfg_two_props cfg_two_props_i (.*);
`default_nettype wire

// ==== dv/cfg_host_model.sv ====
// host model that tickles the outside watchdog on a fixed gap
// assumes the system clock; a pin tickle is a four-cycle high pulse
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  // clock and control from the bench
  input wire logic i_sys_clk,
  input wire logic i_on,
  input wire logic i_pin_sel,
  input wire logic [15:0] i_gap,
  // tickles toward the device
  output logic o_serial_tickle,
  output logic o_pin_tickle
);
  // ----------------------------------------
  // tickle timer
  // ----------------------------------------
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  // wrapping at the gap keeps every tickle inside the interval
  always_comb
  begin
    cnt_d = (!i_on || cnt_q >= i_gap) ? 16'h0 : cnt_q + 16'h1;
  end
  always_ff @(posedge i_sys_clk)
  begin
    cnt_q <= cnt_d;
    o_serial_tickle <= i_on && !i_pin_sel && cnt_q == i_gap;
    o_pin_tickle <= i_on && i_pin_sel && cnt_q < 16'h4;
  end
endmodule : cfg_host_model
`default_nettype wire

// ==== dv/cfg_two_regs_tb_top.sv ====
// self-checking bench for the config word two register bank
// assumes 250 MHz and scaled counts: sleep cycles = us, pin wdt = ms
`timescale 1ns/1ps
`default_nettype none
module cfg_two_regs_tb_top;
  import cfg_two_pkg::*;
  // ----------------------------------------
  // stimulus, outputs and counters
  // ----------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hf;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0, i_ref_low = 1'b0;
  logic [1:0] i_ref_source = 2'h0, o_bresp, o_rresp, r;
  logic [15:0] i_measured_freq = 16'h0, gap = 16'h3c, o_freq_duty;
  logic host_on = 1'b0, pin_sel = 1'b1, i_serial_tickle, i_pin_tickle;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sleep;
  logic o_use_ext_clk, o_cur_gain_auto, o_volt_gain_auto, o_standby;
  logic o_wdt_fault, o_stage_hiz;
  logic [19:0] o_xclk_khz;
  logic [6:0] o_dither_tenths_pct;
  cfg_fields_s o_cfg;
  int miscompares = 0, samples_checked = 0, n;
  always #2 i_sys_clk = ~i_sys_clk;
  cfg_two_regs #(.SLEEP_SCALE(250), .WDT_SCALE(250000)) cfg_two_regs_i (.*);
  cfg_host_model cfg_host_model_i (.i_sys_clk(i_sys_clk), .i_on(host_on),
    .i_pin_sel(pin_sel), .i_gap(gap), .o_serial_tickle(i_serial_tickle),
    .o_pin_tickle(i_pin_tickle));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    @(posedge i_sys_clk iff (o_awready && o_wready));
    i_awvalid <= 1'b0;
    i_wvalid <= 1'b0;
    @(posedge i_sys_clk iff o_bvalid);
    i_bready <= 1'b0;
    r = o_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    @(posedge i_sys_clk iff o_arready);
    i_arvalid <= 1'b0;
    @(posedge i_sys_clk iff o_rvalid);
    i_rready <= 1'b0;
    d = o_rdata;
    r = o_rresp;
  endtask : rd
  // lets registered outputs land before they are judged
  task automatic settle;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask : settle
  // polls the live output each edge; a copied argument would never change
  task automatic wait_for(input bit on_fault, input int lim);
    n = 0;
    while ((on_fault ? o_wdt_fault : o_sleep) !== 1'b1 && n < lim)
    begin
      @(posedge i_sys_clk);
      n++;
    end
  endtask : wait_for
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(8'ha8);
    chk(d, 32'h0);
    rd(8'hc0);
    chk(r, 2'b10);
    wr(8'hc0, 32'hffff_ffff);
    chk(r, 2'b10);
    rd(8'ha8);
    chk(d, 32'h0);
    // only the two middle byte lanes may land
    i_wstrb <= 4'h6;
    wr(8'ha8, 32'hffff_ffff);
    i_wstrb <= 4'hf;
    rd(8'ha8);
    chk(d, 32'h00ff_ff00);
  endtask : t_regs
  task automatic t_fields;
    logic [2:0] k;
    logic [31:0] w;
    logic [6:0] dt[4] = '{7'h0, 7'h32, 7'h4b, 7'h64};
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      w = {13'h0, k, k[1:0], k[2], k[1], 1'b0, k[1:0], k[0], k, 5'h0};
      wr(8'ha8, w);
      rd(8'ha8);
      chk(d, w);
      settle;
      chk(o_cfg, w[30:0]);
      chk(o_xclk_khz, 20'h8 << k);
      chk(o_dither_tenths_pct, dt[k[1:0]]);
      chk({o_use_ext_clk, o_cur_gain_auto}, {k[0], k[2]});
      chk(o_volt_gain_auto, k[1]);
    end
  endtask : t_fields
  task automatic t_duty;
    @(posedge i_sys_clk);
    i_measured_freq <= 16'd250;
    i_ref_source <= 2'h3;
    wr(8'ha8, 32'h03e8_0000);
    settle;
    chk(o_freq_duty, 16'h4000);
    @(posedge i_sys_clk);
    i_measured_freq <= 16'd1000;
    settle;
    chk(o_freq_duty, 16'hffff);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge i_sys_clk);
      i_ref_source <= 2'(s);
      settle;
      chk(o_freq_duty, 16'h0);
    end
  endtask : t_duty
  task automatic t_sleep;
    int lim[3] = '{50, 200, 20000};
    for (int c = 0; c < 3; c++)
    begin
      wr(8'ha8, 32'h800 | (c << 14));
      i_ref_low <= 1'b1;
      repeat (lim[c] / 2) @(posedge i_sys_clk);
      i_ref_low <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_ref_low <= 1'b1;
      wait_for(1'b0, lim[c] + 50);
      chk(n >= lim[c] && n <= lim[c] + 6, 1);
      rd(8'hb0);
      chk(d, 32'h2);
      wr(8'ha8, c << 14);
      settle;
      chk({o_sleep, o_standby}, 2'b01);
      @(posedge i_sys_clk);
      i_ref_low <= 1'b0;
      settle;
      chk({o_sleep, o_standby}, 2'b00);
    end
  endtask : t_sleep
  task automatic t_wdt;
    @(posedge i_sys_clk);
    host_on <= 1'b1;
    wr(8'ha8, 32'h12);
    repeat (400) @(posedge i_sys_clk);
    chk(o_wdt_fault, 1'b0);
    pin_sel <= 1'b0;
    wait_for(1'b1, 200);
    chk(n >= 30 && n <= 110, 1);
    chk(o_stage_hiz, 1'b0);
    gap <= 16'd600;
    wr(8'ha8, 32'h14);
    wr(8'hac, 32'h1);
    repeat (2500) @(posedge i_sys_clk);
    chk(o_wdt_fault, 1'b0);
    wr(8'ha8, 32'h15);
    @(posedge i_sys_clk iff i_serial_tickle);
    host_on <= 1'b0;
    wait_for(1'b1, 2100);
    chk(n >= 1990 && n <= 2008, 1);
    wr(8'hac, 32'h1);
    settle;
    chk({o_stage_hiz, o_wdt_fault}, 2'b10);
  endtask : t_wdt
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_regs;
    t_fields;
    t_duty;
    t_sleep;
    t_wdt;
    conclude;
  end
  // cuts a hang short well past the expected run length
  initial
  begin
    #400000;
    miscompares++;
    conclude;
  end
endmodule : cfg_two_regs_tb_top
`default_nettype wire
